// >>> include/swrs_pkg.sv
// package: register map, field positions, strap codes and timing for the reset and strap controller
`default_nettype none
package swrs_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_SWITCH_CTL = 8'h00;
   localparam logic [7:0] ADDR_UP_LSTS = 8'h04;
   localparam logic [7:0] ADDR_DN_LSTS = 8'h08;
   localparam logic [7:0] ADDR_STRAP_STS = 8'h0C;
   localparam logic [7:0] ADDR_GPIO_CFG = 8'h10;
   localparam logic [7:0] ADDR_STATE_STS = 8'h14;
   // switch control fields
   localparam int CTL_HOLD_BIT = 0;
   // slot clock configuration bit position in a link status word
   localparam int LSTS_SCLK_BIT = 12;
   // downstream ports: 2, 4, 6 map to bits 12..14 of the downstream register
   localparam int NUM_DN = 3;
   localparam int DN_PORT6_IDX = 2;
   // gpio config: bit 0 selects the port 6 reset alternate function
   localparam int GPIO_ALT_BIT = 0;
   localparam logic GPIO_ALT_RESET = 1'b1;
   // switch mode strap codes
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_EEPROM = 3'h1;
   // master bus rates
   localparam int CLK_HZ = 25000000;
   localparam int SMB_SLOW_HZ = 100000;
   localparam int SMB_FAST_HZ = 400000;
   localparam int SMB_SLOW_DIV = CLK_HZ / SMB_SLOW_HZ;
   localparam int SMB_FAST_DIV = CLK_HZ / SMB_FAST_HZ;
   localparam int DIV_W = 9;
   // reset procedure length in cycles
   localparam logic [3:0] RESET_PROC_CYCLES = 4'h8;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_PROC = 2'b01,
      ST_RUN = 2'b11,
      ST_HOLD = 2'b10
   } swrs_state_t;

   typedef struct packed {
      logic [2:0] mode;
      logic hold;
      logic up_cclk;
      logic dn_cclk;
      logic slow;
   } swrs_straps_t;
endpackage
`default_nettype wire

// >>> rtl/swrs_smb_rate.sv
// module: master bus bit-rate enable from the latched slow strap
`default_nettype none
module swrs_smb_rate (
   input wire logic clk,
   input wire logic resetn,
   input wire logic slow,
   input wire logic run,
   output logic tick
);
   logic [swrs_pkg::DIV_W-1:0] cnt_q, cnt_d, limit;
   // rate comes only from the strap; no register reaches this input
   assign limit = slow ? swrs_pkg::DIV_W'(swrs_pkg::SMB_SLOW_DIV - 1)
                       : swrs_pkg::DIV_W'(swrs_pkg::SMB_FAST_DIV - 1);
   always_comb begin
      cnt_d = cnt_q;
      tick = 1'b0;
      if (run) begin
         if (cnt_q >= limit) begin
            cnt_d = '0;
            tick = 1'b1;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule // swrs_smb_rate
`default_nettype wire

// >>> rtl/swrs_ctrl.sv
// module: reset sequencing, strap capture and status registers over AXI4-Lite
// What this block does
// - one gpio may become port 6 downstream reset output as alternate function
// - downstream common clock strap seeds every downstream slot clock bit to the strap value
// - software writes to downstream slot clock bits override the strap seed
// - upstream slot clock bit seeded from upstream strap, software may override
// - slow strap gives 100 KHz master bus, else 400 KHz
// - master bus speed cannot be changed by software
// - fundamental reset clears the sequencer and gpio config (not the bus slave) and starts a fundamental reset
// - hold request during reset keeps device in reset, both buses stay active
// - device leaves hold only when bus master clears the hold bit or a fundamental reset returns it to reset
// - mode straps: 0 normal, 1 eeprom load, 2 to 7 reserved
`default_nettype none
module swrs_ctrl (
   input wire logic clk,
   input wire logic resetn,
   input wire logic fundamental_reset_n,
   input wire logic reset_hold_request,
   input wire logic [2:0] switch_operating_mode_straps,
   input wire logic downstream_common_clock_strap,
   input wire logic upstream_common_clock_strap,
   input wire logic master_bus_slow_strap,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic port6_downstream_reset_out,
   output logic port6_reset_oe_n,
   output logic switch_running,
   output logic core_reset_n,
   output logic eeprom_load_req,
   output logic mode_reserved,
   output logic smb_bit_tick
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [6:0] pin_s1_q, pin_s2_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         pin_s1_q <= {fundamental_reset_n, reset_hold_request, switch_operating_mode_straps,
                      downstream_common_clock_strap, upstream_common_clock_strap};
         pin_s2_q <= pin_s1_q;
      end
   end
   logic perst_n_s;
   swrs_pkg::swrs_straps_t live;
   assign perst_n_s = pin_s2_q[6];
   assign live.hold = pin_s2_q[5];
   assign live.mode = pin_s2_q[4:2];
   assign live.dn_cclk = pin_s2_q[1];
   assign live.up_cclk = pin_s2_q[0];
   // slow strap goes through its own pair to keep the vector tidy
   logic slow_s1_q, slow_s2_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         slow_s1_q <= 1'b0;
         slow_s2_q <= 1'b0;
      end else begin
         slow_s1_q <= master_bus_slow_strap;
         slow_s2_q <= slow_s1_q;
      end
   end
   assign live.slow = slow_s2_q;

   ////////////////////////////////////////////////////////////////////////
   // reset sequencer and strap latch
   swrs_pkg::swrs_state_t st_q, st_d;
   swrs_pkg::swrs_straps_t strap_q, strap_d;
   logic [3:0] proc_q, proc_d;
   logic hold_q, hold_d;
   logic [swrs_pkg::NUM_DN-1:0] dn_sclk_q, dn_sclk_d;
   logic up_sclk_q, up_sclk_d;
   logic gpio_alt_q, gpio_alt_d;
   logic wr_fire;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;

   always_comb begin
      st_d = st_q;
      strap_d = strap_q;
      proc_d = proc_q;
      hold_d = hold_q;
      dn_sclk_d = dn_sclk_q;
      up_sclk_d = up_sclk_q;
      gpio_alt_d = gpio_alt_q;
      if (!perst_n_s) begin
         // sample straps continuously while reset is asserted
         st_d = swrs_pkg::ST_RESET;
         strap_d = live;
         proc_d = '0;
         hold_d = live.hold;
         dn_sclk_d = {swrs_pkg::NUM_DN{live.dn_cclk}};
         up_sclk_d = live.up_cclk;
         gpio_alt_d = 1'b0;
      end else begin
         unique case (st_q)
            swrs_pkg::ST_RESET: begin
               // strap_q frozen from here on; pin changes ignored
               st_d = swrs_pkg::ST_PROC;
            end
            swrs_pkg::ST_PROC: begin
               proc_d = proc_q + 4'h1;
               if (proc_q == swrs_pkg::RESET_PROC_CYCLES - 4'h1) begin
                  st_d = hold_q ? swrs_pkg::ST_HOLD : swrs_pkg::ST_RUN;
               end
            end
            swrs_pkg::ST_HOLD: begin
               if (!hold_q) begin
                  st_d = swrs_pkg::ST_RUN;
               end
            end
            swrs_pkg::ST_RUN: begin
            end
         endcase
         if (wr_fire && wr_strb[0]) begin
            unique case (wr_addr)
               swrs_pkg::ADDR_SWITCH_CTL: begin
                  hold_d = wr_data[swrs_pkg::CTL_HOLD_BIT];
               end
               swrs_pkg::ADDR_GPIO_CFG: begin
                  gpio_alt_d = wr_data[swrs_pkg::GPIO_ALT_BIT];
               end
               default: begin
               end
            endcase
         end
         if (wr_fire && wr_strb[1]) begin
            if (wr_addr == swrs_pkg::ADDR_UP_LSTS) begin
               up_sclk_d = wr_data[swrs_pkg::LSTS_SCLK_BIT];
            end
            if (wr_addr == swrs_pkg::ADDR_DN_LSTS) begin
               for (int i = 0; i < swrs_pkg::NUM_DN; i++) begin
                  dn_sclk_d[i] = wr_data[swrs_pkg::LSTS_SCLK_BIT + i];
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= swrs_pkg::ST_RESET;
         strap_q <= '0;
         proc_q <= '0;
         hold_q <= 1'b0;
         dn_sclk_q <= '0;
         up_sclk_q <= 1'b0;
         gpio_alt_q <= 1'b0;
      end else begin
         st_q <= st_d;
         strap_q <= strap_d;
         proc_q <= proc_d;
         hold_q <= hold_d;
         dn_sclk_q <= dn_sclk_d;
         up_sclk_q <= up_sclk_d;
         gpio_alt_q <= gpio_alt_d;
      end
   end

   assign switch_running = (st_q == swrs_pkg::ST_RUN);
   assign core_reset_n = switch_running;
   assign eeprom_load_req = (st_q == swrs_pkg::ST_PROC) && (strap_q.mode == swrs_pkg::MODE_EEPROM);
   assign mode_reserved = (strap_q.mode != swrs_pkg::MODE_NORMAL) && (strap_q.mode != swrs_pkg::MODE_EEPROM);
   // port 6 held in reset until the switch runs; pin released to gpio when alt off
   assign port6_downstream_reset_out = switch_running;
   assign port6_reset_oe_n = ~gpio_alt_q;

   ////////////////////////////////////////////////////////////////////////
   // master bus rate: strap only, runs in hold too so eeprom and bus stay live
   swrs_smb_rate swrs_smb_rate_inst (
      .clk(clk),
      .resetn(resetn),
      .slow(strap_q.slow),
      .run(st_q != swrs_pkg::ST_RESET),
      .tick(smb_bit_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite slave
   logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
   logic [7:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [3:0] ws_q, ws_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == swrs_pkg::ADDR_SWITCH_CTL) || (a == swrs_pkg::ADDR_UP_LSTS) ||
               (a == swrs_pkg::ADDR_DN_LSTS) || (a == swrs_pkg::ADDR_STRAP_STS) ||
               (a == swrs_pkg::ADDR_GPIO_CFG) || (a == swrs_pkg::ADDR_STATE_STS);
   endfunction

   assign wr_fire = aw_q && w_q && !b_q;
   assign wr_addr = awa_q;
   assign wr_data = wd_q;
   assign wr_strb = ws_q;
   assign s_axi_awready = !aw_q && !b_q;
   assign s_axi_wready = !w_q && !b_q;
   assign s_axi_arready = !r_q;

   always_comb begin
      aw_d = aw_q;
      w_d = w_q;
      b_d = b_q;
      r_d = r_q;
      awa_d = awa_q;
      wd_d = wd_q;
      ws_d = ws_q;
      rd_d = rd_q;
      bresp_d = bresp_q;
      rresp_d = rresp_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_d = 1'b1;
         awa_d = {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_d = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb;
      end
      if (wr_fire) begin
         aw_d = 1'b0;
         w_d = 1'b0;
         b_d = 1'b1;
         bresp_d = mapped(awa_q) ? swrs_pkg::RESP_OKAY : swrs_pkg::RESP_SLVERR;
      end
      if (b_q && s_axi_bready) begin
         b_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         r_d = 1'b1;
         rresp_d = mapped({s_axi_araddr[7:2], 2'b00}) ? swrs_pkg::RESP_OKAY : swrs_pkg::RESP_SLVERR;
         rd_d = '0;
         unique case ({s_axi_araddr[7:2], 2'b00})
            swrs_pkg::ADDR_SWITCH_CTL: rd_d[swrs_pkg::CTL_HOLD_BIT] = hold_q;
            swrs_pkg::ADDR_UP_LSTS: rd_d[swrs_pkg::LSTS_SCLK_BIT] = up_sclk_q;
            swrs_pkg::ADDR_DN_LSTS: rd_d[swrs_pkg::LSTS_SCLK_BIT +: swrs_pkg::NUM_DN] = dn_sclk_q;
            swrs_pkg::ADDR_STRAP_STS: rd_d[6:0] = strap_q;
            swrs_pkg::ADDR_GPIO_CFG: rd_d[swrs_pkg::GPIO_ALT_BIT] = gpio_alt_q;
            swrs_pkg::ADDR_STATE_STS: rd_d[1:0] = st_q;
            default: rd_d = '0;
         endcase
      end else if (r_q && s_axi_rready) begin
         r_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         b_q <= 1'b0;
         r_q <= 1'b0;
         awa_q <= '0;
         wd_q <= '0;
         ws_q <= '0;
         rd_q <= '0;
         bresp_q <= swrs_pkg::RESP_OKAY;
         rresp_q <= swrs_pkg::RESP_OKAY;
      end else begin
         aw_q <= aw_d;
         w_q <= w_d;
         b_q <= b_d;
         r_q <= r_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         ws_q <= ws_d;
         rd_q <= rd_d;
         bresp_q <= bresp_d;
         rresp_q <= rresp_d;
      end
   end
   assign s_axi_bvalid = b_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = r_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rresp_q;

   ////////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_proc_done;
      st_q == swrs_pkg::ST_PROC && proc_q == swrs_pkg::RESET_PROC_CYCLES - 4'h1 && perst_n_s;
   endsequence
   a_hold_entry: assert property (@(posedge clk) disable iff (!resetn)
      s_proc_done ##0 hold_q |=> st_q == swrs_pkg::ST_HOLD)
      else $error("hold not entered after reset procedure");
   a_hold_stays: assert property (@(posedge clk) disable iff (!resetn)
      st_q == swrs_pkg::ST_HOLD && hold_q && perst_n_s |=> st_q == swrs_pkg::ST_HOLD)
      else $error("left hold without clear");
   a_hold_exit: assert property (@(posedge clk) disable iff (!resetn)
      st_q == swrs_pkg::ST_HOLD && !hold_q && perst_n_s |=> st_q == swrs_pkg::ST_RUN)
      else $error("hold not left after clear");
   a_reset_clears: assert property (@(posedge clk) disable iff (!resetn)
      !perst_n_s |=> st_q == swrs_pkg::ST_RESET && !core_reset_n)
      else $error("fundamental reset not honoured");
   a_dn_seed: assert property (@(posedge clk) disable iff (!resetn)
      !perst_n_s |=> dn_sclk_q == {swrs_pkg::NUM_DN{$past(live.dn_cclk)}})
      else $error("downstream slot clock not seeded");
   a_up_seed: assert property (@(posedge clk) disable iff (!resetn)
      !perst_n_s |=> up_sclk_q == $past(live.up_cclk))
      else $error("upstream slot clock not seeded");
   a_strap_frozen: assert property (@(posedge clk) disable iff (!resetn)
      perst_n_s && $past(perst_n_s) |-> $stable(strap_q))
      else $error("straps changed after reset release");
   a_mode_decode: assert property (@(posedge clk) disable iff (!resetn)
      mode_reserved == (strap_q.mode >= 3'h2))
      else $error("mode decode wrong");
   a_dn_write: assert property (@(posedge clk) disable iff (!resetn)
      wr_fire && wr_strb[1] && wr_addr == swrs_pkg::ADDR_DN_LSTS && perst_n_s
      |=> dn_sclk_q == $past(wr_data[swrs_pkg::LSTS_SCLK_BIT +: swrs_pkg::NUM_DN]))
      else $error("downstream slot clock write lost");
   a_p6_reset: assert property (@(posedge clk) disable iff (!resetn)
      !port6_reset_oe_n && st_q != swrs_pkg::ST_RUN |-> !port6_downstream_reset_out)
      else $error("port 6 reset released early");
endmodule // swrs_ctrl
`default_nettype wire

// >>> sim/swrs_board_model.sv
// board side model: reset pin driver and strap wiring
`default_nettype none
module swrs_board_model (
   input wire logic clk,
   input wire logic pin_low_req,
   input wire logic allow_change,
   input wire swrs_pkg::swrs_straps_t want,
   output var logic fundamental_reset_n,
   output var swrs_pkg::swrs_straps_t straps
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      fundamental_reset_n = 1'b0;
      straps = 7'h00;
   end

   always @(posedge clk) begin
      fundamental_reset_n <= ~pin_low_req;
      // straps only move while reset is low, unless a scenario breaks that on purpose
      if (!fundamental_reset_n || allow_change) begin
         straps <= want;
      end
   end
endmodule // swrs_board_model
`default_nettype wire

// >>> sim/tb_switch_reset_and_strap_control.sv
// testbench: reset sequencing, strap capture, slot clock seeds and bus rate
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_switch_reset_and_strap_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic pin_low_req = 1'b1;
   logic allow_change = 1'b0;
   swrs_pkg::swrs_straps_t want = 7'h00;
   swrs_pkg::swrs_straps_t straps;
   logic fundamental_reset_n;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, p6_out, p6_oe_n, running, core_n, eep_req, resv, tick;
   logic [1:0] bresp, rresp;
   int miscompares = 0;
   int samples_checked = 0;

   always #20 clk = ~clk;

   swrs_board_model swrs_board_model_inst (.clk(clk), .pin_low_req(pin_low_req), .allow_change(allow_change),
      .want(want), .fundamental_reset_n(fundamental_reset_n), .straps(straps));

   swrs_ctrl swrs_ctrl_inst (.clk(clk), .resetn(resetn), .fundamental_reset_n(fundamental_reset_n),
      .reset_hold_request(straps.hold), .switch_operating_mode_straps(straps.mode),
      .downstream_common_clock_strap(straps.dn_cclk), .upstream_common_clock_strap(straps.up_cclk),
      .master_bus_slow_strap(straps.slow), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port6_downstream_reset_out(p6_out),
      .port6_reset_oe_n(p6_oe_n), .switch_running(running), .core_reset_n(core_n),
      .eeprom_load_req(eep_req), .mode_reserved(resv), .smb_bit_tick(tick));

   ////////////////////////////////////////////////////////////////////////////
   // bus tasks: enter and leave just after a rising edge
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      logic aw_go, w_go, b_go;
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      r = 2'h3;
      for (n = 0; n < 50; n++) begin
         // decide on the falling edge, act after the rising one
         @(negedge clk);
         aw_go = awvalid & awready;
         w_go = wvalid & wready;
         b_go = bvalid & bready;
         r = bresp;
         @(posedge clk);
         if (aw_go) awvalid <= 1'b0;
         if (w_go) wvalid <= 1'b0;
         if (b_go) begin
            bready <= 1'b0;
            break;
         end
      end
      // one idle edge so a following call never re-raises bready in the same step
      @(posedge clk);
      `CHK("write answer", 1'b1, n < 50)
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ar_go, r_go;
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      d = 32'h0;
      r = 2'h3;
      for (n = 0; n < 50; n++) begin
         @(negedge clk);
         ar_go = arvalid & arready;
         r_go = rvalid & rready;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ar_go) arvalid <= 1'b0;
         if (r_go) begin
            rready <= 1'b0;
            break;
         end
      end
      @(posedge clk);
      `CHK("read answer", 1'b1, n < 50)
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axw(a, d, r);
      `CHK("write resp", swrs_pkg::RESP_OKAY, r)
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
      logic [31:0] d;
      logic [1:0] r;
      axr(a, d, r);
      `CHK(nm, e, d & m)
      `CHK("read resp", swrs_pkg::RESP_OKAY, r)
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // board helpers
   task automatic boot(input swrs_pkg::swrs_straps_t s, output logic eep);
      int n;
      want <= s;
      pin_low_req <= 1'b1;
      repeat (6) @(posedge clk);
      pin_low_req <= 1'b0;
      eep = 1'b0;
      // long enough to cover sync, procedure and the final state
      for (n = 0; n < 30; n++) begin
         @(negedge clk);
         if (eep_req === 1'b1) eep = 1'b1;
      end
      @(posedge clk);
   endtask

   task automatic tick_period(input int e, input string nm);
      int n, p;
      @(negedge clk);
      for (n = 0; n < 1000 && tick !== 1'b1; n++) @(negedge clk);
      @(negedge clk);
      for (p = 1; p < 1000 && tick !== 1'b1; p++) @(negedge clk);
      `CHK(nm, e, p)
      @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset_state;
      repeat (4) @(negedge clk);
      `CHK("running in reset", 1'b0, running)
      `CHK("core in reset", 1'b0, core_n)
      `CHK("p6 oe_n in reset", 1'b1, p6_oe_n)
      @(posedge clk);
      chk_rd(swrs_pkg::ADDR_STATE_STS, 32'h3, 32'h0, "state in reset");
      $display("test reset_state done");
   endtask

   task automatic t_hold_boot;
      logic eep;
      boot(7'h1F, eep);
      `CHK("eeprom load", 1'b1, eep)
      `CHK("core held", 1'b0, core_n)
      chk_rd(swrs_pkg::ADDR_STATE_STS, 32'h3, 32'h2, "held state");
      chk_rd(swrs_pkg::ADDR_STRAP_STS, 32'h7F, 32'h1F, "strap latch");
      chk_rd(swrs_pkg::ADDR_UP_LSTS, 32'h1000, 32'h1000, "up seed");
      chk_rd(swrs_pkg::ADDR_DN_LSTS, 32'h7000, 32'h7000, "dn seed");
      wr(swrs_pkg::ADDR_DN_LSTS, 32'h0000_1000);
      chk_rd(swrs_pkg::ADDR_DN_LSTS, 32'h7000, 32'h1000, "dn override");
      wr(swrs_pkg::ADDR_UP_LSTS, 32'h0);
      chk_rd(swrs_pkg::ADDR_UP_LSTS, 32'h1000, 32'h0, "up override");
      want <= 7'h00;
      allow_change <= 1'b1;
      repeat (6) @(posedge clk);
      allow_change <= 1'b0;
      chk_rd(swrs_pkg::ADDR_STRAP_STS, 32'h7F, 32'h1F, "strap after change");
      chk_rd(swrs_pkg::ADDR_STATE_STS, 32'h3, 32'h2, "still held");
      wr(swrs_pkg::ADDR_SWITCH_CTL, 32'h0);
      for (int n = 0; n < 40 && core_n !== 1'b1; n++) @(negedge clk);
      @(posedge clk);
      `CHK("running after release", 1'b1, running)
      `CHK("mode not reserved", 1'b0, resv)
      $display("test hold_boot done");
   endtask

   task automatic t_rate_slow;
      logic [1:0] r;
      tick_period(swrs_pkg::SMB_SLOW_DIV, "slow period");
      axw(swrs_pkg::ADDR_STRAP_STS, 32'h0, r);
      chk_rd(swrs_pkg::ADDR_STRAP_STS, 32'h1, 32'h1, "slow strap kept");
      tick_period(swrs_pkg::SMB_SLOW_DIV, "slow after write");
      $display("test rate_slow done");
   endtask

   task automatic t_fast_reserved;
      logic eep;
      boot(7'h30, eep);
      `CHK("no eeprom load", 1'b0, eep)
      `CHK("mode reserved", 1'b1, resv)
      `CHK("run without hold", 1'b1, running)
      chk_rd(swrs_pkg::ADDR_UP_LSTS, 32'h1000, 32'h0, "up seed zero");
      chk_rd(swrs_pkg::ADDR_DN_LSTS, 32'h7000, 32'h0, "dn seed zero");
      tick_period(swrs_pkg::SMB_FAST_DIV, "fast period");
      $display("test fast_reserved done");
   endtask

   task automatic t_gpio_alt;
      logic [31:0] d;
      logic [1:0] r;
      logic eep;
      // normal mode with only the downstream strap set: catches a swapped seed
      boot(7'h02, eep);
      `CHK("normal no eeprom", 1'b0, eep)
      `CHK("normal not reserved", 1'b0, resv)
      `CHK("normal running", 1'b1, running)
      chk_rd(swrs_pkg::ADDR_DN_LSTS, 32'h7000, 32'h7000, "dn seed only");
      chk_rd(swrs_pkg::ADDR_UP_LSTS, 32'h1000, 32'h0, "up seed only");
      wr(swrs_pkg::ADDR_GPIO_CFG, 32'h1);
      @(negedge clk);
      `CHK("p6 oe_n alt", 1'b0, p6_oe_n)
      `CHK("p6 out running", 1'b1, p6_out)
      @(posedge clk);
      pin_low_req <= 1'b1;
      repeat (6) @(negedge clk);
      `CHK("p6 out in reset", 1'b0, p6_out)
      `CHK("p6 oe_n in reset", 1'b1, p6_oe_n)
      `CHK("stopped in reset", 1'b0, running)
      @(posedge clk);
      chk_rd(swrs_pkg::ADDR_GPIO_CFG, 32'h1, 32'h0, "alt cleared");
      axw(8'h40, 32'h1, r);
      `CHK("unmapped write", swrs_pkg::RESP_SLVERR, r)
      axr(8'h40, d, r);
      `CHK("unmapped read", swrs_pkg::RESP_SLVERR, r)
      `CHK("unmapped data", 32'h0, d)
      $display("test gpio_alt done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d miscompares %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_reset_state;
      t_hold_boot;
      t_rate_slow;
      t_fast_reserved;
      t_gpio_alt;
      finish_test;
   end

   // the scenarios take well under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      $display("ERROR watchdog expected done seen hang");
      finish_test;
   end
endmodule // tb_switch_reset_and_strap_control
`default_nettype wire
